/* rtl/hppa_port.v */
`include "hppa_regs.vh"
`default_nettype none

module hppa_fifo #(
  parameter WIDTH = 64,
  parameter DEPTH = 4
) (
  input  wire             i_clk,
  input  wire             i_nrst,
  // Fill side
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_in_ready,
  // Drain side
  output reg              o_out_valid,
  output wire [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready
);
  localparam CW = $clog2(DEPTH + 1);
  localparam [CW-1:0] FULL = DEPTH;
  localparam [CW-1:0] ONE  = 1;
  localparam [CW-1:0] NONE = 0;

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [CW-1:0]    cnt;
  wire             push = i_in_valid && (cnt != FULL);
  wire             pop  = o_out_valid && i_out_ready;
  wire [CW-1:0]    next_cnt = cnt + (push ? ONE : NONE) - (pop ? ONE : NONE);

  assign o_in_ready = (cnt != FULL);
  assign o_out_data = mem[0];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_entry
      localparam [CW-1:0] IDX = i;
      wire [WIDTH-1:0] upper;
      if (i == DEPTH - 1)
      begin : g_last
        assign upper = mem[i];
      end
      else
      begin : g_mid
        assign upper = mem[i+1];
      end
      // Entry 0 is always the head, so the head output is a flop
      always @(posedge i_clk)
      begin
        if (pop)
        begin
          if (push && (IDX + ONE == cnt))
            mem[i] <= i_in_data;
          else
            mem[i] <= upper;
        end
        else if (push && (IDX == cnt))
          mem[i] <= i_in_data;
      end
    end
  endgenerate

  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      cnt         <= NONE;
      o_out_valid <= 1'b0;
    end
    else
    begin
      cnt         <= next_cnt;
      o_out_valid <= (next_cnt != NONE);
    end
  end
endmodule

module hppa_port (
  // Clock and reset
  input  wire                    i_clk,
  input  wire                    i_nrst,
  // Host pins
  input  wire [1:0]              i_access_select,
  input  wire                    i_port_select_n,
  input  wire                    i_host_dir,
  input  wire                    i_halfword_id,
  input  wire                    i_data_strobe_a,
  input  wire                    i_data_strobe_b,
  input  wire [`HPPA_BUS_W-1:0]  i_host_bus,
  output reg  [`HPPA_BUS_W-1:0]  o_host_bus,
  output reg                     o_host_bus_oe,
  output reg                     o_host_wait,
  output reg                     o_host_irq_n,
  // Processor side
  input  wire                    i_cpu_host_irq_set,
  input  wire                    i_cpu_irq_ack,
  output reg                     o_cpu_irq,
  output reg                     o_dual_addr_en,
  output reg                     o_addr_reg_sel,
  output reg                     o_hw_order,
  output reg  [`HPPA_WORD_W-1:0] o_read_addr_reg,
  output reg  [`HPPA_WORD_W-1:0] o_write_addr_reg,
  // Memory read mover
  output reg                     o_rd_req,
  output reg  [`HPPA_WORD_W-1:0] o_rd_addr,
  input  wire                    i_rd_valid,
  input  wire [`HPPA_WORD_W-1:0] i_rd_data,
  // Memory write mover, fed from the FIFO
  output wire                    o_wr_valid,
  output wire [`HPPA_WORD_W-1:0] o_wr_addr,
  output wire [`HPPA_WORD_W-1:0] o_wr_data,
  input  wire                    i_wr_ready
);
  localparam [2:0] ST_IDLE  = `HPPA_ST_IDLE;
  localparam [2:0] ST_FETCH = `HPPA_ST_FETCH;
  localparam [2:0] ST_HOLD  = `HPPA_ST_HOLD;

  // Three-stage synchronisers; a level counts once stages two and three agree
  wire [`HPPA_SYNC_W-1:0] pins = {i_host_bus, i_access_select, i_port_select_n,
                                  i_host_dir, i_halfword_id, i_data_strobe_a, i_data_strobe_b};
  reg  [`HPPA_SYNC_W-1:0] s1;
  reg  [`HPPA_SYNC_W-1:0] s2;
  reg  [`HPPA_SYNC_W-1:0] s3;
  reg  [`HPPA_SYNC_W-1:0] st;

  genvar b;
  generate
    for (b = 0; b < `HPPA_SYNC_W; b = b + 1)
    begin : g_sync
      always @(posedge i_clk)
      begin
        if (!i_nrst)
        begin
          s1[b] <= 1'b1;
          s2[b] <= 1'b1;
          s3[b] <= 1'b1;
          st[b] <= 1'b1;
        end
        else
        begin
          s1[b] <= pins[b];
          s2[b] <= s1[b];
          s3[b] <= s2[b];
          if (s2[b] == s3[b])
            st[b] <= s3[b];
        end
      end
    end
  endgenerate

  wire [`HPPA_BUS_W-1:0] st_bus  = st[22:7];
  wire [1:0]             st_sel  = st[6:5];
  wire                   st_cs_n = st[4];
  wire                   st_dir  = st[3];
  wire                   st_hid  = st[2];

  // Internal strobe: either data strobe away from the other, gated by select
  wire strobe_on = !st_cs_n && (st[1] ^ st[0]);
  reg  strobe_prev;
  wire strobe_fall = strobe_on && !strobe_prev;
  wire strobe_rise = strobe_prev && !(st[1] ^ st[0]) && !st_cs_n;

  reg  [2:0]              state;
  reg  [1:0]              cur_sel;
  reg                     cur_dir;
  reg                     cur_hid;
  reg  [`HPPA_BUS_W-1:0]  hold_half;
  reg  [`HPPA_WORD_W-1:0] fetched;
  reg                     host_irq;
  reg                     fifo_in_valid;
  reg  [2*`HPPA_WORD_W-1:0] fifo_in_data;
  wire                    fifo_in_ready;

  wire cur_data = cur_sel[1];
  wire cur_inc  = (cur_sel == `HPPA_SEL_DATA_INC);

  // Word presented to the host for a read
  reg [`HPPA_WORD_W-1:0] rd_word;
  always @*
  begin
    case (cur_sel)
      `HPPA_SEL_CTRL:
        rd_word = {27'h0000000, o_addr_reg_sel, o_dual_addr_en, host_irq, o_cpu_irq, o_hw_order};
      `HPPA_SEL_ADDR:
        if (o_dual_addr_en && !o_addr_reg_sel)
          rd_word = o_write_addr_reg;
        else
          rd_word = o_read_addr_reg;
      default:
        rd_word = fetched;
    endcase
  end

  // Halfword order: hw_order set puts the low half first
  wire [`HPPA_BUS_W-1:0] rd_half = (cur_hid ^ o_hw_order) ? rd_word[15:0] : rd_word[31:16];
  wire [`HPPA_WORD_W-1:0] wr_word = o_hw_order ? {st_bus, hold_half} : {hold_half, st_bus};

  wire host_irq_clr = strobe_rise && !cur_dir && (cur_sel == `HPPA_SEL_CTRL)
                      && st_bus[`HPPA_CTL_HOST_IRQ];
  wire cpu_irq_set  = strobe_rise && !cur_dir && (cur_sel == `HPPA_SEL_CTRL)
                      && st_bus[`HPPA_CTL_CPU_IRQ];
  wire next_host_irq = (host_irq && !host_irq_clr) || i_cpu_host_irq_set;

  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      strobe_prev      <= 1'b0;
      state            <= ST_IDLE;
      cur_sel          <= `HPPA_SEL_CTRL;
      cur_dir          <= 1'b0;
      cur_hid          <= 1'b0;
      hold_half        <= `HPPA_HALF_RST;
      fetched          <= `HPPA_WORD_RST;
      host_irq         <= 1'b0;
      o_host_irq_n     <= 1'b1;
      o_cpu_irq        <= 1'b0;
      o_dual_addr_en   <= 1'b0;
      o_addr_reg_sel   <= 1'b0;
      o_hw_order       <= 1'b0;
      o_read_addr_reg  <= `HPPA_ADDR_RST;
      o_write_addr_reg <= `HPPA_ADDR_RST;
      o_rd_req         <= 1'b0;
      o_rd_addr        <= `HPPA_ADDR_RST;
      o_host_bus       <= `HPPA_HALF_RST;
      o_host_bus_oe    <= 1'b0;
      o_host_wait      <= 1'b0;
      fifo_in_valid    <= 1'b0;
      fifo_in_data     <= {`HPPA_WORD_RST, `HPPA_WORD_RST};
    end
    else
    begin
      strobe_prev   <= strobe_on;
      o_rd_req      <= 1'b0;
      fifo_in_valid <= 1'b0;
      host_irq      <= next_host_irq;
      o_host_irq_n  <= !next_host_irq;
      o_cpu_irq     <= (o_cpu_irq && !i_cpu_irq_ack) || cpu_irq_set;

      case (state)
        ST_IDLE:
        begin
          o_host_bus_oe <= 1'b0;
          o_host_wait   <= 1'b0;
          if (strobe_fall)
          begin
            cur_sel <= st_sel;
            cur_dir <= st_dir;
            cur_hid <= st_hid;
            if (st_dir && st_sel[1] && !st_hid)
            begin
              // Data read: fetch through the read address register
              o_rd_req    <= 1'b1;
              o_rd_addr   <= o_read_addr_reg;
              o_host_wait <= 1'b1;
              state       <= ST_FETCH;
            end
            else
              state <= ST_HOLD;
          end
        end

        ST_FETCH:
        begin
          o_host_wait <= 1'b1;
          if (i_rd_valid)
          begin
            fetched <= i_rd_data;
            if (cur_inc)
            begin
              // Increment the read register only after it was used
              o_read_addr_reg <= o_read_addr_reg + `HPPA_ADDR_STEP;
              if (!o_dual_addr_en)
                o_write_addr_reg <= o_write_addr_reg + `HPPA_ADDR_STEP;
            end
            state <= ST_HOLD;
          end
          if (!strobe_on)
            state <= ST_IDLE;
        end

        ST_HOLD:
        begin
          if (cur_dir)
          begin
            o_host_bus    <= rd_half;
            o_host_bus_oe <= strobe_on;
            o_host_wait   <= 1'b0;
          end
          else
            o_host_wait <= cur_data && !fifo_in_ready;
          if (strobe_rise && !cur_dir)
          begin
            if (!cur_hid)
              hold_half <= st_bus;
            case (cur_sel)
              `HPPA_SEL_CTRL:
              begin
                o_hw_order     <= st_bus[`HPPA_CTL_HW_ORDER];
                o_dual_addr_en <= st_bus[`HPPA_CTL_DUAL];
                o_addr_reg_sel <= st_bus[`HPPA_CTL_ADDR_SEL];
              end
              `HPPA_SEL_ADDR:
                if (cur_hid)
                begin
                  if (!o_dual_addr_en || o_addr_reg_sel)
                    o_read_addr_reg <= wr_word;
                  if (!o_dual_addr_en || !o_addr_reg_sel)
                    o_write_addr_reg <= wr_word;
                end
              default:
                if (cur_hid)
                begin
                  fifo_in_valid <= 1'b1;
                  fifo_in_data  <= {o_write_addr_reg, wr_word};
                  if (cur_inc)
                  begin
                    o_write_addr_reg <= o_write_addr_reg + `HPPA_ADDR_STEP;
                    if (!o_dual_addr_en)
                      o_read_addr_reg <= o_read_addr_reg + `HPPA_ADDR_STEP;
                  end
                  // Fixed-address code leaves both registers alone
                end
            endcase
          end
          if (!strobe_on)
          begin
            o_host_bus_oe <= 1'b0;
            state         <= ST_IDLE;
          end
        end

        default:
          state <= ST_IDLE;
      endcase

      // Deselect drops the wait output and the bus at once
      if (st_cs_n)
      begin
        o_host_wait   <= 1'b0;
        o_host_bus_oe <= 1'b0;
      end
    end
  end

  hppa_fifo #(
    .WIDTH (2*`HPPA_WORD_W),
    .DEPTH (`HPPA_FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (fifo_in_valid),
    .i_in_data   (fifo_in_data),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (o_wr_valid),
    .o_out_data  ({o_wr_addr, o_wr_data}),
    .i_out_ready (i_wr_ready)
  );
endmodule

`default_nettype wire

/* rtl/hppa_regs.vh */
`ifndef HPPA_REGS_VH
`define HPPA_REGS_VH

// Access type codes on access_select
`define HPPA_SEL_CTRL      2'h0
`define HPPA_SEL_ADDR      2'h1
`define HPPA_SEL_DATA_INC  2'h2
`define HPPA_SEL_DATA_FIX  2'h3

// Control register bit positions
`define HPPA_CTL_HW_ORDER  0
`define HPPA_CTL_CPU_IRQ   1
`define HPPA_CTL_HOST_IRQ  2
`define HPPA_CTL_DUAL      3
`define HPPA_CTL_ADDR_SEL  4

// Widths, reset values and step sizes
`define HPPA_BUS_W         16
`define HPPA_WORD_W        32
`define HPPA_ADDR_RST      32'h00000000
`define HPPA_WORD_RST      32'h00000000
`define HPPA_HALF_RST      16'h0000
`define HPPA_ADDR_STEP     32'h00000004
`define HPPA_FIFO_DEPTH    4
`define HPPA_SYNC_W        23

// Transfer states, one-hot
`define HPPA_ST_IDLE       3'h1
`define HPPA_ST_FETCH      3'h2
`define HPPA_ST_HOLD       3'h4

`endif

/* tb/hppa_host.sv */
`default_nettype none
module hppa_host (
  // Clock and port answers
  input  wire logic        i_clk,
  input  wire logic        i_wait,
  input  wire logic        i_oe,
  input  wire logic [15:0] i_rbus,
  // Host pins
  output logic [1:0]       o_code,
  output logic             o_sel_n,
  output logic             o_dir,
  output logic             o_hid,
  output logic             o_sa,
  output logic             o_sb,
  output logic [15:0]      o_bus,
  // Set when the port never answers
  output logic             o_stuck
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {o_code, o_dir, o_hid, o_sa, o_sb, o_bus} = '0;
    o_sel_n = 1'b1;
    o_stuck = 1'b0;
    // Pin mux is taken as set for the dual-halfword bus before any transfer
  end
  // One halfword; the address strobe is not a pin here, it sits high
  task automatic half(input logic [1:0] c, input logic d, h, s, input logic [15:0] wd,
                      output logic [15:0] rd);
    int   n;
    logic p;
    p = 1'($urandom);
    @(negedge i_clk);
    o_sel_n = s;
    o_code = c;
    o_dir = d;
    o_hid = h;
    o_bus = d ? ~o_bus : wd;
    @(negedge i_clk);
    if (p)
      o_sa = ~o_sa;
    else
      o_sb = ~o_sb;
    repeat (8) @(negedge i_clk);
    n = 0;
    while ((i_wait === 1'b1 || (d && !s && i_oe !== 1'b1)) && n < 300)
    begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 300)
      o_stuck = 1'b1;
    rd = i_rbus;
    if (p)
      o_sa = ~o_sa;
    else
      o_sb = ~o_sb;
    repeat (6) @(negedge i_clk);
    o_bus = ~o_bus;
  endtask
endmodule
`default_nettype wire

/* tb/hppa_port_asserts.sv */
`default_nettype none
module hppa_port_asserts (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_nrst,
  // Inputs
  input wire logic        i_port_select_n,
  input wire logic        i_data_strobe_a,
  input wire logic        i_data_strobe_b,
  input wire logic        i_cpu_host_irq_set,
  input wire logic        i_rd_valid,
  input wire logic        i_wr_ready,
  // Outputs
  input wire logic        o_host_bus_oe,
  input wire logic        o_host_wait,
  input wire logic        o_host_irq_n,
  input wire logic        o_dual_addr_en,
  input wire logic [31:0] o_read_addr_reg,
  input wire logic [31:0] o_write_addr_reg,
  input wire logic        o_rd_req,
  input wire logic [31:0] o_rd_addr,
  input wire logic        o_wr_valid,
  input wire logic [31:0] o_wr_addr,
  input wire logic [31:0] o_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  AST_DESEL: assert property (i_port_select_n [*6] |-> !o_host_bus_oe && !o_host_wait)
    else $error("port active while deselected");
  AST_OE_IDLE: assert property (!(i_data_strobe_a ^ i_data_strobe_b) [*8] |-> !o_host_bus_oe)
    else $error("bus driven without strobe");
  AST_RD_PULSE: assert property (o_rd_req |=> !o_rd_req)
    else $error("read request longer than one cycle");
  AST_RD_WAIT: assert property (o_rd_req |-> o_host_wait)
    else $error("not waiting during fetch");
  AST_RD_ADDR: assert property (o_rd_req |-> o_rd_addr == o_read_addr_reg)
    else $error("fetch address not read register");
  AST_RD_DONE: assert property (o_host_wait && i_rd_valid |-> ##2 (!o_host_wait && o_host_bus_oe))
    else $error("fetched data not released");
  AST_IRQ_SET: assert property (i_cpu_host_irq_set |-> ##[1:2] !o_host_irq_n)
    else $error("host interrupt not raised");
  AST_SINGLE: assert property (!o_dual_addr_en && $changed(o_read_addr_reg) |-> $changed(o_write_addr_reg))
    else $error("shared address registers diverge");
  AST_DUAL: assert property (o_dual_addr_en && $changed(o_read_addr_reg) |-> $stable(o_write_addr_reg))
    else $error("both address registers moved");
  AST_WR_HOLD: assert property (o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable({o_wr_addr, o_wr_data}))
    else $error("write head changed while stalled");
endmodule
bind hppa_port hppa_port_asserts chk_u (.i_clk, .i_nrst, .i_port_select_n, .i_data_strobe_a,
  .i_data_strobe_b, .i_cpu_host_irq_set, .i_rd_valid, .i_wr_ready, .o_host_bus_oe, .o_host_wait,
  .o_host_irq_n, .o_dual_addr_en, .o_read_addr_reg, .o_write_addr_reg, .o_rd_req, .o_rd_addr,
  .o_wr_valid, .o_wr_addr, .o_wr_data);
`default_nettype wire

/* tb/hppa_port_tb.sv */
`include "hppa_regs.vh"
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module hppa_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, sel_n, dir, hid, sa, sb, irq_set, irq_ack, rd_valid, wr_ready;
  logic        o_host_bus_oe, o_host_wait, o_host_irq_n, o_cpu_irq, o_dual_addr_en;
  logic        o_addr_reg_sel, o_hw_order, o_rd_req, o_wr_valid, hw, dual, sel;
  logic        stall = 1'b0;
  logic        stuck;
  logic [1:0]  code;
  logic [15:0] hbus, o_host_bus, h16;
  wire  [15:0] bus_w;
  logic [31:0] o_read_addr_reg, o_write_addr_reg, o_rd_addr, o_wr_addr, o_wr_data;
  logic [31:0] rd_data, ra, wa, raddr, r;
  logic [63:0] q[$];
  logic [63:0] e;
  int          error_cnt, comparisons;
  assign bus_w = o_host_bus_oe ? o_host_bus : hbus;
  hppa_port dut_u (.i_clk(clk), .i_nrst(nrst), .i_access_select(code), .i_port_select_n(sel_n),
    .i_host_dir(dir), .i_halfword_id(hid), .i_data_strobe_a(sa), .i_data_strobe_b(sb),
    .i_host_bus(bus_w), .o_host_bus(o_host_bus), .o_host_bus_oe(o_host_bus_oe),
    .o_host_wait(o_host_wait), .o_host_irq_n(o_host_irq_n), .i_cpu_host_irq_set(irq_set),
    .i_cpu_irq_ack(irq_ack), .o_cpu_irq(o_cpu_irq), .o_dual_addr_en(o_dual_addr_en),
    .o_addr_reg_sel(o_addr_reg_sel), .o_hw_order(o_hw_order), .o_read_addr_reg(o_read_addr_reg),
    .o_write_addr_reg(o_write_addr_reg), .o_rd_req(o_rd_req), .o_rd_addr(o_rd_addr),
    .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr),
    .o_wr_data(o_wr_data), .i_wr_ready(wr_ready));
  hppa_host host_u (.i_clk(clk), .i_wait(o_host_wait), .i_oe(o_host_bus_oe), .i_rbus(bus_w),
    .o_code(code), .o_sel_n(sel_n), .o_dir(dir), .o_hid(hid), .o_sa(sa), .o_sb(sb), .o_bus(hbus),
    .o_stuck(stuck));
  function automatic logic [31:0] mem(input logic [31:0] a);
    return {a[15:0], ~a[31:16]};
  endfunction
  task automatic conclude;
    if (stuck !== 1'b0)
      error_cnt++;
    $display("%0d comparisons, %0d errors", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic word(input logic [1:0] c, input logic d, input logic [31:0] w, output logic [31:0] rw);
    logic [15:0] a, b;
    host_u.half(c, d, 1'b0, 1'b0, hw ? w[15:0] : w[31:16], a);
    host_u.half(c, d, 1'b1, 1'b0, hw ? w[31:16] : w[15:0], b);
    rw = hw ? {b, a} : {a, b};
  endtask
  task automatic regs;
    `CHK(o_read_addr_reg, ra)
    `CHK(o_write_addr_reg, wa)
  endtask
  task automatic ctl(input logic [4:0] v);
    {sel, dual, hw} = {v[4:3], v[0]};
    host_u.half(`HPPA_SEL_CTRL, 1'b0, 1'b0, 1'b0, {11'h000, v}, h16);
    host_u.half(`HPPA_SEL_CTRL, 1'b0, 1'b1, 1'b0, {11'h000, v}, h16);
    `CHK({o_addr_reg_sel, o_dual_addr_en, o_hw_order}, {sel, dual, hw})
  endtask
  task automatic aw(input logic [31:0] w);
    w = w & 32'hFFFFFFFC;
    word(`HPPA_SEL_ADDR, 1'b0, w, r);
    if (!dual || sel)
      ra = w;
    if (!dual || !sel)
      wa = w;
    regs();
  endtask
  task automatic dw(input logic [1:0] c, input logic [31:0] w);
    q.push_back({wa, w});
    word(c, 1'b0, w, r);
    if (c == `HPPA_SEL_DATA_INC && !dual)
      ra += `HPPA_ADDR_STEP;
    if (c == `HPPA_SEL_DATA_INC)
      wa += `HPPA_ADDR_STEP;
    regs();
  endtask
  task automatic dr(input logic [1:0] c);
    word(c, 1'b1, 32'h0, r);
    `CHK(raddr, ra)
    `CHK(r, mem(ra))
    if (c == `HPPA_SEL_DATA_INC && !dual)
      wa += `HPPA_ADDR_STEP;
    if (c == `HPPA_SEL_DATA_INC)
      ra += `HPPA_ADDR_STEP;
    regs();
  endtask
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial forever
  begin
    wr_ready = stall ? 1'b0 : 1'($urandom);
    @(negedge clk);
  end
  // Memory read side answers after a random latency
  initial forever
  begin
    @(posedge clk);
    if (o_rd_req === 1'b1)
    begin
      raddr = o_rd_addr;
      repeat (1 + $urandom % 4) @(negedge clk);
      rd_data = mem(raddr);
      rd_valid = 1'b1;
      @(negedge clk);
      rd_valid = 1'b0;
      rd_data = ~rd_data;
    end
  end
  always @(posedge clk)
    if (nrst && o_wr_valid === 1'b1 && wr_ready === 1'b1)
    begin
      e = q.pop_front();
      `CHK({o_wr_addr, o_wr_data}, e)
    end
  initial
  begin
    #(40 * 30000);
    error_cnt++;
    conclude();
  end
  initial
  begin
    {nrst, irq_set, irq_ack, rd_valid, rd_data, ra, wa} = '0;
    void'($urandom(76));
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    `CHK({o_host_irq_n, o_host_wait, o_host_bus_oe}, 3'h4)
    regs();
    $display("reset test done");
    for (int m = 0; m < 4; m++)
    begin
      ctl({m[0] ^ m[1], m[1], 2'b00, m[0]});
      aw($urandom);
      word(`HPPA_SEL_ADDR, 1'b1, 32'h0, r);
      `CHK(r, dual && !sel ? wa : ra)
      dw(`HPPA_SEL_DATA_INC, $urandom);
      dw(`HPPA_SEL_DATA_FIX, $urandom);
      aw($urandom);
      dr(`HPPA_SEL_DATA_INC);
      dr(`HPPA_SEL_DATA_FIX);
      $display("address mode test %0d done", m);
    end
    @(negedge clk) irq_set = 1'b1;
    @(negedge clk) irq_set = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(o_host_irq_n, 1'b0)
    ctl(5'h04);
    `CHK(o_host_irq_n, 1'b1)
    ctl(5'h02);
    `CHK(o_cpu_irq, 1'b1)
    @(negedge clk) irq_ack = 1'b1;
    @(negedge clk) irq_ack = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(o_cpu_irq, 1'b0)
    $display("interrupt test done");
    host_u.half(`HPPA_SEL_ADDR, 1'b0, 1'b0, 1'b1, 16'h1230, h16);
    host_u.half(`HPPA_SEL_ADDR, 1'b0, 1'b1, 1'b1, 16'h4560, h16);
    regs();
    $display("deselect test done");
    stall = 1'b1;
    repeat (`HPPA_FIFO_DEPTH) dw(`HPPA_SEL_DATA_FIX, $urandom);
    `CHK(o_wr_valid, 1'b1)
    stall = 1'b0;
    repeat (60) @(negedge clk);
    `CHK(q.size(), 0)
    $display("buffer test done");
    conclude();
  end
endmodule
`default_nettype wire
